// *** hw/pief_top.sv ***
// The Wishbone register port and the register offsets are this design's own decisions.
`include "pief_defines.svh"
`default_nettype none
module pief_top #(
	parameter int ADR_W = 8,
	parameter int DAT_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire pief_pkg::pief_evt_t evt_i,
	input wire pief_pkg::pief_ccmode_t ccp_mode_i,
	output logic irq_o
);

	// the register map is one byte wide in a 32-bit word
	if (DAT_W != 32 || ADR_W < 4) begin : g_chk
		$error("pief_top: needs DAT_W 32 and ADR_W at least 4");
	end

	// address decode shared by read and write paths
	function automatic pief_pkg::pief_sel_t dec(
		input logic [ADR_W-1:0] a
	);
		pief_pkg::pief_sel_t s;
		s = pief_pkg::PIEF_SEL_NONE;
		if ((a >> 4) == '0) begin
			case ({4'h0, a[3:0]})
				`PIEF_OFS_EN1: s = pief_pkg::PIEF_SEL_EN1;
				`PIEF_OFS_EN2: s = pief_pkg::PIEF_SEL_EN2;
				`PIEF_OFS_REQ1: s = pief_pkg::PIEF_SEL_REQ;
				`PIEF_OFS_CTRL: s = pief_pkg::PIEF_SEL_CTRL;
				default: s = pief_pkg::PIEF_SEL_NONE;
			endcase
		end
		return s;
	endfunction

	logic [6:0] en1;
	logic [3:0] en2;
	logic [6:0] req;
	logic global_irq_en;
	logic pme;
	logic req_hit;
	logic wr_stb;
	logic [6:0] flags;
	logic [6:0] set_ev;
	logic [7:0] next_rd;
	logic any_pend;
	pief_pkg::pief_sel_t sel;

	// request taken on the first cycle, answered one edge later
	assign req_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign sel = dec(wb_adr_i);
	// writes land at the edge where the master sees ack
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o
		& wb_sel_i[0];

	// acknowledge: one cycle pulse for every access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_hit;
		end
	end

	// enable registers, zero at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en1 <= `PIEF_RST_EN1;
			en2 <= `PIEF_RST_EN2;
		end else if (wr_stb) begin
			if (sel == pief_pkg::PIEF_SEL_EN1) begin
				en1 <= wb_dat_i[6:0];
			end
			if (sel == pief_pkg::PIEF_SEL_EN2) begin
				en2 <= wb_dat_i[7:`PIEF_B_EN2_LSB];
			end
		end
	end

	// master enables, mirroring the core control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_en <= 1'b0;
			pme <= 1'b0;
		end else if (wr_stb && sel == pief_pkg::PIEF_SEL_CTRL) begin
			global_irq_en <= wb_dat_i[`PIEF_B_GIE];
			pme <= wb_dat_i[`PIEF_B_PME];
		end
	end

	// hardware set events per flag bit
	always_comb begin
		set_ev = '0;
		set_ev[`PIEF_B_CONV] = evt_i.conv_done;
		set_ev[`PIEF_B_SYNC] = evt_i.sync_done;
		if (ccp_mode_i == pief_pkg::PIEF_CAPTURE) begin
			set_ev[`PIEF_B_CAPCMP] = evt_i.capture;
		end else begin
			set_ev[`PIEF_B_CAPCMP] = evt_i.compare;
		end
		set_ev[`PIEF_B_T2] = evt_i.t2_match;
		set_ev[`PIEF_B_T1] = evt_i.t1_ovf;
	end

	// sticky flags: set ignores enables, set beats the write
	for (genvar i = 0; i < 7; i++) begin : g_flag
		localparam logic [6:0] WM = `PIEF_REQ_WMASK;
		if (WM[i]) begin : g_sticky
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					req[i] <= 1'b0;
				end else if (set_ev[i]) begin
					req[i] <= 1'b1;
				end else if (wr_stb
					&& sel == pief_pkg::PIEF_SEL_REQ) begin
					req[i] <= wb_dat_i[i];
				end
			end
			// stored bit follows the write unless an event lands too
			a_flag_write: assert property (
				@(posedge clk_i) disable iff (rst_i)
				wr_stb && sel == pief_pkg::PIEF_SEL_REQ && !set_ev[i]
				|=> req[i] == $past(wb_dat_i[i])
			) else $error("flag write not stored");
			a_flag_event: assert property (
				@(posedge clk_i) disable iff (rst_i)
				set_ev[i] |=> req[i]
			) else $error("flag not set by its event");
			a_flag_hold: assert property (
				@(posedge clk_i) disable iff (rst_i)
				req[i] && !(wr_stb && sel == pief_pkg::PIEF_SEL_REQ)
				|=> req[i]
			) else $error("flag dropped without a write");
		end else begin : g_live
			assign req[i] = 1'b0;
		end
	end

	// serial buffer status shows through live, cleared upstream
	always_comb begin
		flags = req;
		flags[`PIEF_B_RX] = evt_i.rx_full;
		flags[`PIEF_B_TX] = evt_i.tx_empty;
	end

	// read multiplexer, unimplemented bits read zero
	always_comb begin
		next_rd = 8'h00;
		case (sel)
			pief_pkg::PIEF_SEL_EN1: next_rd = {1'b0, en1};
			pief_pkg::PIEF_SEL_EN2: next_rd = {en2, 4'h0};
			pief_pkg::PIEF_SEL_REQ: next_rd = {1'b0, flags};
			pief_pkg::PIEF_SEL_CTRL: next_rd = {global_irq_en, pme, 6'h00};
			default: next_rd = 8'h00;
		endcase
	end

	// read data captured with the acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req_hit) begin
			wb_dat_o <= {24'h00_0000, next_rd};
		end
	end

	// any enabled source pending, before the master enables
	assign any_pend = |(flags & en1);

	// peripheral request: masked OR, then both master enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= any_pend & pme & global_irq_en;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_en1_top_zero: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_EN1
		|=> wb_ack_o && wb_dat_o[31:7] == '0
	) else $error("enable 1 unimplemented bits not zero");

	a_en2_low_zero: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_EN2
		|=> wb_dat_o[3:0] == 4'h0 && wb_dat_o[31:8] == '0
	) else $error("enable 2 low bits not zero");

	a_en_write_back: assert property (
		wr_stb && sel == pief_pkg::PIEF_SEL_EN1
		|=> en1 == $past(wb_dat_i[6:0])
	) else $error("enable 1 write not stored");

	a_pme_blocks_irq: assert property (
		!pme |=> !irq_o
	) else $error("request passed with master enable clear");

	a_pme_passes_irq: assert property (
		pme && global_irq_en && (|(flags & en1)) |=> irq_o
	) else $error("unmasked request not passed on");

	a_flag_set_any: assert property (
		evt_i.conv_done && !en1[`PIEF_B_CONV] && !pme
		|=> req[`PIEF_B_CONV]
	) else $error("flag not set with enables clear");

	a_conv_hold: assert property (
		req[`PIEF_B_CONV] && !(wr_stb
		&& sel == pief_pkg::PIEF_SEL_REQ)
		|=> req[`PIEF_B_CONV]
	) else $error("conversion flag dropped without write");

	a_rx_live_read: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_REQ
		|=> wb_dat_o[`PIEF_B_RX] == $past(evt_i.rx_full)
	) else $error("receive flag does not mirror buffer");

	a_tx_live_read: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_REQ
		|=> wb_dat_o[`PIEF_B_TX] == $past(evt_i.tx_empty)
	) else $error("transmit flag does not mirror buffer");

	a_sync_set: assert property (
		evt_i.sync_done |=> req[`PIEF_B_SYNC] [*1]
	) else $error("sync serial flag not set");

	a_capture_set: assert property (
		ccp_mode_i == pief_pkg::PIEF_CAPTURE && evt_i.capture
		|=> req[`PIEF_B_CAPCMP]
	) else $error("capture did not set flag");

	a_compare_set: assert property (
		ccp_mode_i == pief_pkg::PIEF_COMPARE && evt_i.compare
		|=> req[`PIEF_B_CAPCMP]
	) else $error("compare match did not set flag");

	a_timer_set: assert property (
		evt_i.t2_match && evt_i.t1_ovf
		|=> req[`PIEF_B_T2] && req[`PIEF_B_T1]
	) else $error("timer flags not set");

	a_irq_cause: assert property (
		irq_o |-> $past(any_pend) && $past(pme)
		&& $past(global_irq_en)
	) else $error("request raised without cause");

	a_set_beats_write: assert property (
		wr_stb && sel == pief_pkg::PIEF_SEL_REQ
		&& evt_i.t1_ovf && !wb_dat_i[`PIEF_B_T1]
		|=> req[`PIEF_B_T1]
	) else $error("software write beat hardware set");

	a_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held longer than one cycle");

	a_ack_follows_req: assert property (
		req_hit |=> wb_ack_o
	) else $error("request not acknowledged");

	a_ack_needs_req: assert property (
		!req_hit |=> !wb_ack_o
	) else $error("ack without a request");

	a_rd_upper_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == '0
	) else $error("read data above the byte not zero");

	a_unmapped_zero: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_NONE
		|=> wb_dat_o == '0
	) else $error("unmapped address read not zero");

	a_en1_read_back: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_EN1
		|=> wb_dat_o[6:0] == $past(en1)
	) else $error("enable 1 read does not match");

	a_en2_write_back: assert property (
		wr_stb && sel == pief_pkg::PIEF_SEL_EN2
		|=> en2 == $past(wb_dat_i[7:4])
	) else $error("enable 2 write not stored");

	a_en2_read_back: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_EN2
		|=> wb_dat_o[7:4] == $past(en2)
	) else $error("enable 2 read does not match");

	a_sel0_ignored: assert property (
		wb_ack_o && wb_we_i && !wb_sel_i[0]
		|=> $stable(en1) && $stable(en2)
	) else $error("write with byte lane off changed enables");

	a_ctrl_write_back: assert property (
		wr_stb && sel == pief_pkg::PIEF_SEL_CTRL
		|=> global_irq_en == $past(wb_dat_i[7]) && pme == $past(wb_dat_i[6])
	) else $error("control write not stored");

	a_ctrl_read_back: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_CTRL
		|=> wb_dat_o[7:0] == {$past(global_irq_en), $past(pme), 6'h00}
	) else $error("control read does not match");

	a_gie_blocks_irq: assert property (
		!global_irq_en |=> !irq_o
	) else $error("request passed with global enable clear");

	a_irq_drops: assert property (
		!any_pend |=> !irq_o
	) else $error("request raised with nothing pending");

	a_req_read_back: assert property (
		req_hit && sel == pief_pkg::PIEF_SEL_REQ
		|=> wb_dat_o[7:0] == {1'b0, $past(flags)}
	) else $error("request register read does not match");

endmodule
`default_nettype wire

// *** hw/pief_defines.svh ***
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

// register byte offsets on the bus
`define PIEF_OFS_EN1 8'h00
`define PIEF_OFS_EN2 8'h04
`define PIEF_OFS_REQ1 8'h08
`define PIEF_OFS_CTRL 8'h0C

// reset values
`define PIEF_RST_EN1 7'h00
`define PIEF_RST_EN2 4'h0
`define PIEF_RST_REQ1 7'h00

// first enable / request register bit positions
`define PIEF_B_CONV 6
`define PIEF_B_RX 5
`define PIEF_B_TX 4
`define PIEF_B_SYNC 3
`define PIEF_B_CAPCMP 2
`define PIEF_B_T2 1
`define PIEF_B_T1 0

// second enable register field, bits 7..4
`define PIEF_B_EN2_LSB 4
`define PIEF_B_OSC_FAIL 7
`define PIEF_B_CMP_B 6
`define PIEF_B_CMP_A 5
`define PIEF_B_NVM 4

// control register bits, laid out as in the core control register
`define PIEF_B_GIE 7
`define PIEF_B_PME 6

// flag bits that software may write; bits 5 and 4 are live status
`define PIEF_REQ_WMASK 7'h4F

`endif

// *** hw/pief_pkg.sv ***
`default_nettype none
package pief_pkg;

	// one event or status line per request source, except capture and compare, which both feed the one capture/compare flag
	typedef struct packed {
		logic conv_done;
		logic rx_full;
		logic tx_empty;
		logic sync_done;
		logic capture;
		logic compare;
		logic t2_match;
		logic t1_ovf;
	} pief_evt_t;

	// capture/compare unit mode
	typedef enum logic {
		PIEF_CAPTURE,
		PIEF_COMPARE
	} pief_ccmode_t;

	// decoded register target
	typedef enum logic [2:0] {
		PIEF_SEL_EN1,
		PIEF_SEL_EN2,
		PIEF_SEL_REQ,
		PIEF_SEL_CTRL,
		PIEF_SEL_NONE
	} pief_sel_t;

endpackage
`default_nettype wire

// *** tb/pief_top_tb.sv ***
`include "pief_defines.svh"
`default_nettype none
module pief_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] q;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	pief_pkg::pief_evt_t ev = '0;
	pief_pkg::pief_ccmode_t md = pief_pkg::PIEF_CAPTURE;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 32'hc551_06dd;
	logic [7:0] ofs [5] = '{`PIEF_OFS_EN1, `PIEF_OFS_EN2, `PIEF_OFS_REQ1,
		`PIEF_OFS_CTRL, 8'h10};

	pief_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.evt_i(ev), .ccp_mode_i(md), .irq_o(irq_o));

	// free-running system clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_irq(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t irq %h exp %h", $time, g, e);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// one-cycle event pulse, returns on the edge irq updates
	task automatic pulse(input pief_pkg::pief_evt_t e);
		ev <= e;
		@(posedge clk_i);
		ev <= '0;
		@(posedge clk_i);
	endtask

	// flag image expected after a pulse pattern
	function automatic logic [31:0] exp_req(pief_pkg::pief_evt_t e,
		logic m);
		return {25'h0, e.conv_done, e.rx_full, e.tx_empty, e.sync_done,
			m ? e.compare : e.capture, e.t2_match, e.t1_ovf};
	endfunction

	// interrupt level from flags, mask and control
	function automatic logic exp_irq(logic [31:0] f,
		logic [31:0] en, logic [31:0] c);
		return |(f & en & 32'h0000_007f) & c[`PIEF_B_GIE]
			& c[`PIEF_B_PME];
	endfunction

	// main sequence
	initial begin
		logic [31:0] d;
		logic [31:0] c;
		logic [31:0] f;
		pief_pkg::pief_evt_t e;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ofs[i]) begin
			wb(1'b0, ofs[i], 32'h0000_0000);
			chk(q, 32'h0000_0000);
		end
		$display("test reset done");
		repeat (8) begin
			d = $random(seed);
			wb(1'b1, `PIEF_OFS_EN1, d);
			wb(1'b0, `PIEF_OFS_EN1, 32'h0000_0000);
			chk(q, d & 32'h0000_007f);
			wb(1'b1, `PIEF_OFS_EN2, d);
			wb(1'b0, `PIEF_OFS_EN2, 32'h0000_0000);
			chk(q, d & 32'h0000_00f0);
		end
		sel <= 4'h0;
		wb(1'b1, `PIEF_OFS_EN1, ~d);
		sel <= 4'hf;
		wb(1'b0, `PIEF_OFS_EN1, 32'h0000_0000);
		chk(q, d & 32'h0000_007f);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		$display("test enables done");
		repeat (24) begin
			d = $random(seed);
			c = $random(seed);
			wb(1'b1, `PIEF_OFS_REQ1, 32'h0000_0000);
			wb(1'b1, `PIEF_OFS_EN1, d);
			wb(1'b1, `PIEF_OFS_CTRL, c);
			e = pief_pkg::pief_evt_t'(d[15:8] & 8'h9f);
			md <= pief_pkg::pief_ccmode_t'(d[16]);
			pulse(e);
			f = exp_req(e, d[16]);
			wb(1'b0, `PIEF_OFS_REQ1, 32'h0000_0000);
			chk(q, f);
			chk_irq(irq_o, exp_irq(f, d, c));
		end
		wb(1'b1, `PIEF_OFS_REQ1, 32'h0000_0000);
		wb(1'b0, `PIEF_OFS_REQ1, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		$display("test flags done");
		ev <= pief_pkg::pief_evt_t'(8'h60);
		wb(1'b1, `PIEF_OFS_REQ1, 32'h0000_0000);
		wb(1'b0, `PIEF_OFS_REQ1, 32'h0000_0000);
		chk(q, 32'h0000_0030);
		// overflow lands on the very edge where the clearing write does
		fork
			wb(1'b1, `PIEF_OFS_REQ1, 32'h0000_0000);
			begin
				@(posedge clk_i);
				ev <= pief_pkg::pief_evt_t'(8'h01);
				@(posedge clk_i);
				ev <= '0;
			end
		join
		wb(1'b0, `PIEF_OFS_REQ1, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		$display("test live flags done");
		test_done();
	end
endmodule
`default_nettype wire
